// ===== common/fdc_pkg.sv
// Register map, field layouts and carrier types of the flight-data channel config block
package fdc_pkg;
  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] FDC_OFF_CTRL = 8'h00;
  localparam logic [7:0] FDC_OFF_SYNC1 = 8'h04;
  localparam logic [7:0] FDC_OFF_SYNC2 = 8'h08;
  localparam logic [7:0] FDC_OFF_SYNC3 = 8'h0C;
  localparam logic [7:0] FDC_OFF_SYNC4 = 8'h10;
  localparam logic [7:0] FDC_OFF_STATUS = 8'h14;
  localparam logic [7:0] FDC_OFF_RATE = 8'h18;
  localparam logic [7:0] FDC_OFF_FRAME = 8'h1C;
  // Control word: width, writable bits and reset value
  localparam int unsigned FDC_CTRL_W = 17;
  localparam logic [16:0] FDC_CTRL_MASK = 17'h1FF77;
  localparam logic [16:0] FDC_CTRL_RST = 17'h00000;
  // Sync patterns and their reset values
  localparam int unsigned FDC_SYNC_W = 12;
  localparam int unsigned FDC_SYNC_N = 4;
  localparam logic [11:0] FDC_SYNC1_RST = 12'h001;
  localparam logic [11:0] FDC_SYNC2_RST = 12'h002;
  localparam logic [11:0] FDC_SYNC3_RST = 12'h003;
  localparam logic [11:0] FDC_SYNC4_RST = 12'h004;
  // Rate code 0 base values, each code step doubles them
  localparam logic [12:0] FDC_BASE_WORDS = 13'h0020;
  localparam logic [15:0] FDC_BASE_BPS = 16'h0180;
  // Status word field positions
  localparam int unsigned FDC_STAT_LOCK_POS = 0;
  localparam int unsigned FDC_STAT_STATE_POS = 1;
  localparam int unsigned FDC_STAT_IDX_POS = 4;
  localparam int unsigned FDC_STAT_LOSS_POS = 8;
  localparam logic [7:0] FDC_LOSS_MAX = 8'hFF;

  typedef enum logic [1:0] {
    FDC_ST_OFF = 2'b00,
    FDC_ST_HUNT = 2'b01,
    FDC_ST_CHECK = 2'b10,
    FDC_ST_LOCK = 2'b11
  } fdc_hunt_t;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } fdc_word_t;

  typedef struct packed {
    logic tx_buffer_enable;
    logic rx_buffer_enable;
    logic rx_shared_buffer_enable;
    logic rx_loopback_select;
    logic tx_slew_select;
    logic tx_biphase_encoding_enable;
    logic tx_rz_encoding_enable;
    logic rx_line_code_select;
    logic frame_autodetect_enable;
    logic rsv_7;
    logic [2:0] tx_rate_select;
    logic rsv_3;
    logic [2:0] rx_rate_select;
  } fdc_ctrl_t;

  typedef struct packed {
    fdc_hunt_t state;
    logic [1:0] idx;
    logic [12:0] cnt;
    logic lock;
  } fdc_hunt_st_t;

  typedef struct packed {
    logic line;
    fdc_word_t sel;
    fdc_word_t own;
    fdc_word_t shared;
  } fdc_route_st_t;

  typedef struct packed {
    fdc_ctrl_t ctrl;
    logic [3:0][11:0] sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    fdc_word_t tx;
    logic lock_d;
    logic [7:0] loss;
  } fdc_regs_t;

  // Words per sub-frame for a rate code
  function automatic logic [12:0] fdc_subframe_len(input logic [2:0] rate);
    return FDC_BASE_WORDS << rate;
  endfunction

  // Bits per second for a rate code
  function automatic logic [15:0] fdc_bit_rate(input logic [2:0] rate);
    return FDC_BASE_BPS << rate;
  endfunction
endpackage

// ===== hw/fdc_rx_route.sv
// Receive source select and own or shared buffer steering
`timescale 1ns/1ps
module fdc_rx_route (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic loop_i,
  input wire logic shared_i,
  input wire logic buf_en_i,
  input wire logic line_i,
  input wire logic loop_line_i,
  input wire fdc_pkg::fdc_word_t word_i,
  input wire fdc_pkg::fdc_word_t loop_word_i,
  output logic line_o,
  output fdc_pkg::fdc_word_t sel_o,
  output fdc_pkg::fdc_word_t own_o,
  output fdc_pkg::fdc_word_t shared_o
);
  import fdc_pkg::*;
  fdc_route_st_t s_ff;
  fdc_route_st_t nxt_s;

  // Wrap swaps in the looped transmit signal; the words then go to the own or the shared buffer, or to neither while buffering is off
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.line = loop_i ? loop_line_i : line_i;
    nxt_s.sel = loop_i ? loop_word_i : word_i;
    nxt_s.own = nxt_s.sel;
    nxt_s.shared = nxt_s.sel;
    nxt_s.own.valid = nxt_s.sel.valid && buf_en_i && !shared_i;
    nxt_s.shared.valid = nxt_s.sel.valid && buf_en_i && shared_i;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign line_o = s_ff.line;
  assign sel_o = s_ff.sel;
  assign own_o = s_ff.own;
  assign shared_o = s_ff.shared;
endmodule

// ===== hw/fdc_sync_hunt.sv
// Frame sync hunter: walks the four sync patterns at sub-frame spacing
`timescale 1ns/1ps
module fdc_sync_hunt (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [2:0] rate_i,
  input wire fdc_pkg::fdc_word_t word_i,
  input wire logic [fdc_pkg::FDC_SYNC_N-1:0][fdc_pkg::FDC_SYNC_W-1:0] sync_i,
  output fdc_pkg::fdc_hunt_t state_o,
  output logic [1:0] idx_o,
  output logic lock_o
);
  import fdc_pkg::*;
  fdc_hunt_st_t s_ff;
  fdc_hunt_st_t nxt_s;
  logic [12:0] len;
  logic hit;

  // Expected pattern and spacing for the current rate
  assign len = fdc_subframe_len(rate_i);
  assign hit = (word_i.data == sync_i[s_ff.idx]);

  // A miss at a pattern slot restarts the hunt; a rate change that overruns the count makes the next word a pattern slot
  always_comb
  begin
    nxt_s = s_ff;
    if (!en_i)
    begin
      nxt_s = '{state: FDC_ST_OFF, idx: 2'h0, cnt: 13'h0000, lock: 1'b0};
    end
    else
    begin
      case (s_ff.state)
        FDC_ST_OFF: nxt_s.state = FDC_ST_HUNT;
        FDC_ST_HUNT:
          if (word_i.valid && hit)
          begin
            nxt_s.state = FDC_ST_CHECK;
            nxt_s.idx = 2'h1;
            nxt_s.cnt = 13'h0001;
          end
        FDC_ST_CHECK, FDC_ST_LOCK:
          if (word_i.valid && (s_ff.cnt < len))
          begin
            nxt_s.cnt = s_ff.cnt + 13'h0001;
          end
          else if (word_i.valid && hit)
          begin
            nxt_s.idx = s_ff.idx + 2'h1;
            nxt_s.cnt = 13'h0001;
            if (s_ff.idx == 2'h3)
            begin
              nxt_s.state = FDC_ST_LOCK;
              nxt_s.lock = 1'b1;
            end
          end
          else if (word_i.valid)
          begin
            nxt_s = '{state: FDC_ST_HUNT, idx: 2'h0, cnt: 13'h0000, lock: 1'b0};
          end
        default: nxt_s.state = FDC_ST_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_ff <= '{state: FDC_ST_OFF, idx: 2'h0, cnt: 13'h0000, lock: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign state_o = s_ff.state;
  assign idx_o = s_ff.idx;
  assign lock_o = s_ff.lock;
endmodule

// ===== hw/fdc_top.sv
// Flight-data channel configuration: APB register file, receive routing and frame sync hunt
//
// How it works
// - Rate codes 0 to 7 double the bit rate from 384 bps and the sub-frame from 32 words.
// - Receive and transmit each keep their own rate code.
// - An auto-detect enable starts the sync search, and while clear no search runs.
// - One receive setting picks bi-phase or bipolar return-to-zero decoding.
// - A transmit enable selects bipolar return-to-zero encoding.
// - A separate transmit enable selects bi-phase encoding.
// - Four 12-bit sync patterns are held and each must be loaded nonzero.
// - Wrap makes the receiver take the looped transmit signal instead of the line.
// - Shared mode sends received words to the common buffer instead of the own one.
// - Receive and transmit buffering each stop while their enable is clear.
// - The slew select drives 1 for fast edges and 0 for slow edges.
//
// Map: CTRL 0x00, SYNC1..4 0x04-0x10, STATUS 0x14, RATE 0x18, FRAME 0x1C.
`timescale 1ns/1ps
module fdc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_line_i,
  input wire logic tx_loop_line_i,
  input wire fdc_pkg::fdc_word_t rx_word_i,
  input wire fdc_pkg::fdc_word_t tx_word_i,
  output fdc_pkg::fdc_ctrl_t cfg_o,
  output logic rx_line_o,
  output fdc_pkg::fdc_word_t own_word_o,
  output fdc_pkg::fdc_word_t shared_word_o,
  output fdc_pkg::fdc_word_t tx_word_o,
  output logic frame_lock_o
);
  import fdc_pkg::*;
  fdc_regs_t r_ff;
  fdc_regs_t nxt_r;
  fdc_word_t sel_word;
  fdc_hunt_t hunt_state;
  logic [1:0] hunt_idx;
  logic hunt_lock;
  logic take_ph;
  logic resp_ph;
  logic [31:0] rd_val;
  logic rd_ok;
  logic sync_slot;
  logic [1:0] sync_idx;
  logic loss_evt;
  logic loss_clr;

  // APB phases: the answer is raised one cycle into the access phase
  assign take_ph = psel_i && penable_i && !r_ff.pready;
  assign resp_ph = psel_i && penable_i && r_ff.pready;
  assign sync_idx = 2'(paddr_i[4:2] - 3'h1);

  // Lock loss events, counted for software; a status write clears the count
  assign loss_evt = r_ff.lock_d && !hunt_lock;
  assign loss_clr = resp_ph && pwrite_i && (paddr_i == FDC_OFF_STATUS);

  // Address decode and read data; unmapped offsets answer with an error and zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    sync_slot = 1'b0;
    case (paddr_i)
      FDC_OFF_CTRL: rd_val = {15'h0000, r_ff.ctrl};
      FDC_OFF_SYNC1, FDC_OFF_SYNC2, FDC_OFF_SYNC3, FDC_OFF_SYNC4:
      begin
        sync_slot = 1'b1;
        rd_val = {20'h00000, r_ff.sync[sync_idx]};
      end
      FDC_OFF_STATUS:
      begin
        rd_val[FDC_STAT_LOCK_POS] = hunt_lock;
        rd_val[FDC_STAT_STATE_POS +: 2] = hunt_state;
        rd_val[FDC_STAT_IDX_POS +: 2] = hunt_idx;
        rd_val[FDC_STAT_LOSS_POS +: 8] = r_ff.loss;
      end
      FDC_OFF_RATE:
        rd_val = {fdc_bit_rate(r_ff.ctrl.tx_rate_select), fdc_bit_rate(r_ff.ctrl.rx_rate_select)};
      FDC_OFF_FRAME:
        rd_val = {3'h0, fdc_subframe_len(r_ff.ctrl.tx_rate_select),
                  3'h0, fdc_subframe_len(r_ff.ctrl.rx_rate_select)};
      default: rd_ok = 1'b0;
    endcase
  end

  // Next state of the register file and the transmit gate
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.pready = take_ph;
    // Answer fields are latched once, so they hold steady through the response cycle
    if (take_ph)
    begin
      nxt_r.prdata = pwrite_i ? 32'h0000_0000 : rd_val;
      nxt_r.pslverr = !rd_ok || (pwrite_i && sync_slot && (pwdata_i[11:0] == 12'h000));
    end
    // A refused write leaves every register untouched
    if (resp_ph && pwrite_i && !r_ff.pslverr)
    begin
      case (paddr_i)
        FDC_OFF_CTRL: nxt_r.ctrl = fdc_ctrl_t'(pwdata_i[FDC_CTRL_W-1:0] & FDC_CTRL_MASK);
        FDC_OFF_SYNC1, FDC_OFF_SYNC2, FDC_OFF_SYNC3, FDC_OFF_SYNC4:
          nxt_r.sync[sync_idx] = pwdata_i[FDC_SYNC_W-1:0];
        default: nxt_r.ctrl = r_ff.ctrl;
      endcase
    end
    // A loss in the clearing cycle still counts
    if (loss_evt && loss_clr)
      nxt_r.loss = 8'h01;
    else if (loss_evt && (r_ff.loss != FDC_LOSS_MAX))
      nxt_r.loss = r_ff.loss + 8'h01;
    else if (loss_clr)
      nxt_r.loss = 8'h00;
    nxt_r.lock_d = hunt_lock;
    nxt_r.tx.data = tx_word_i.data;
    nxt_r.tx.valid = tx_word_i.valid && r_ff.ctrl.tx_buffer_enable;
  end

  // Register file state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r_ff <= '{ctrl: fdc_ctrl_t'(FDC_CTRL_RST),
                sync: {FDC_SYNC4_RST, FDC_SYNC3_RST, FDC_SYNC2_RST, FDC_SYNC1_RST},
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h0000_0000,
                tx: '0,
                lock_d: 1'b0,
                loss: 8'h00};
    else
      r_ff <= nxt_r;
  end

  // Outputs straight from the state flops
  assign prdata_o = r_ff.prdata;
  assign pready_o = r_ff.pready;
  assign pslverr_o = r_ff.pslverr;
  assign cfg_o = r_ff.ctrl;
  assign tx_word_o = r_ff.tx;
  assign frame_lock_o = hunt_lock;

  // Receive source and buffer steering
  fdc_rx_route u_route (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .loop_i(r_ff.ctrl.rx_loopback_select),
    .shared_i(r_ff.ctrl.rx_shared_buffer_enable),
    .buf_en_i(r_ff.ctrl.rx_buffer_enable),
    .line_i(rx_line_i),
    .loop_line_i(tx_loop_line_i),
    .word_i(rx_word_i),
    .loop_word_i(r_ff.tx),
    .line_o(rx_line_o),
    .sel_o(sel_word),
    .own_o(own_word_o),
    .shared_o(shared_word_o)
  );

  // Frame sync hunt on the selected word stream
  fdc_sync_hunt u_hunt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(r_ff.ctrl.frame_autodetect_enable),
    .rate_i(r_ff.ctrl.rx_rate_select),
    .word_i(sel_word),
    .sync_i(r_ff.sync),
    .state_o(hunt_state),
    .idx_o(hunt_idx),
    .lock_o(hunt_lock)
  );

  // Bus phases as the master drives them
  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  sequence s_access;
    psel_i && penable_i;
  endsequence

  sequence s_ctrl_write;
    psel_i && penable_i && pready_o && pwrite_i && (paddr_i == FDC_OFF_CTRL);
  endsequence

  // Every access is answered on its second access cycle, for exactly one cycle
  property p_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_setup ##1 s_access |-> !pready_o ##1 pready_o ##1 !pready_o;
  endproperty
  a_answer: assert property (p_answer) else $error("access not answered in two cycles");

  // A zero pattern is refused and the slot keeps its value
  property p_sync_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && !pready_o && pwrite_i && sync_slot &&
     (pwdata_i[11:0] == 12'h000)) ##1 pready_o |-> pslverr_o ##1 $stable(r_ff.sync);
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("zero sync pattern accepted");

  // Rate readback follows the doubling law of both codes
  property p_rate_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && pready_o && !pwrite_i && (paddr_i == FDC_OFF_RATE)) |->
      (prdata_o == {FDC_BASE_BPS << cfg_o.tx_rate_select, FDC_BASE_BPS << cfg_o.rx_rate_select});
  endproperty
  a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");

  // Control write lands on the next cycle with reserved bit 7 cleared
  property p_ctrl_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_ctrl_write ##0 !pslverr_o |=> (cfg_o.rx_rate_select == $past(pwdata_i[2:0])) &&
      (cfg_o.tx_rate_select == $past(pwdata_i[6:4])) && (cfg_o.rsv_7 == 1'b0);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("rate codes not stored");

  // Slew and encoding selects move only through a control write
  property p_cfg_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    !(psel_i && penable_i && pready_o && pwrite_i && (paddr_i == FDC_OFF_CTRL)) |=>
      $stable({cfg_o.tx_slew_select, cfg_o.tx_rz_encoding_enable,
               cfg_o.tx_biphase_encoding_enable, cfg_o.rx_line_code_select});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("line settings changed unasked");

  // Stopped transmit buffering passes no words
  property p_tx_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
    !cfg_o.tx_buffer_enable |=> !tx_word_o.valid;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx word passed while stopped");

  // Stopped receive buffering fills neither buffer
  property p_rx_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
    !cfg_o.rx_buffer_enable |=> !own_word_o.valid && !shared_word_o.valid;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx word passed while stopped");

  // Shared mode keeps the own buffer quiet and feeds the shared one
  property p_shared;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cfg_o.rx_shared_buffer_enable && cfg_o.rx_buffer_enable && !cfg_o.rx_loopback_select &&
     rx_word_i.valid) |=> !own_word_o.valid && shared_word_o.valid;
  endproperty
  a_shared: assert property (p_shared) else $error("shared steering wrong");

  // Wrap follows the looped transmit line
  property p_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
    cfg_o.rx_loopback_select |=> (rx_line_o == $past(tx_loop_line_i));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap source not taken");

  // No lock survives a cleared auto-detect enable
  property p_autodetect_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    !cfg_o.frame_autodetect_enable |=> !frame_lock_o && (hunt_state == FDC_ST_OFF);
  endproperty
  a_autodetect_off: assert property (p_autodetect_off) else $error("search ran while off");

  // Lock rises only from the check walk on its fourth pattern
  property p_lock_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(frame_lock_o) |-> ($past(hunt_state) == FDC_ST_CHECK) && ($past(hunt_idx) == 2'h3)
      && (hunt_idx == 2'h0);
  endproperty
  a_lock_entry: assert property (p_lock_entry) else $error("lock without full walk");

  // Offsets above FRAME answer with an error and zero data
  property p_unmapped;
    @(posedge clk_i) disable iff (!rst_n_i)
    (psel_i && penable_i && pready_o && (paddr_i > FDC_OFF_FRAME)) |->
      pslverr_o && (prdata_o == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule

// ===== tb/fdc_line_model.sv
// Far-side flight-data line model: serves decoded words and a line level
`timescale 1ns/1ps
module fdc_line_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic send_i,
  input wire logic [11:0] data_i,
  output fdc_pkg::fdc_word_t word_o,
  output logic line_o
);
  import fdc_pkg::*;
  // One word per request; between words the data inverts on every cycle, so it shows the last word again on alternate cycles
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      word_o <= '0;
      line_o <= 1'b0;
    end
    else
    begin
      word_o.valid <= send_i;
      word_o.data <= send_i ? data_i : ~word_o.data;
      line_o <= send_i ? data_i[11] : line_o; // Idle line keeps its level
    end
  end
endmodule

// ===== tb/fdc_top_tb.sv
// Self-checking bench for the flight-data channel configuration block
`timescale 1ns/1ps
module fdc_top_tb;
  import fdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx_line_o, frame_lock_o, rx_line_i;
  logic tx_loop_line_i = 1'b0;
  logic send = 1'b0;
  logic [11:0] sdata = 12'h000;
  fdc_word_t rx_word_i, own_word_o, shared_word_o, tx_word_o;
  fdc_word_t tx_word_i = '0;
  fdc_ctrl_t cfg_o;
  int n_mismatch = 0;
  int tests_run = 0;

  always #25 clk_i = ~clk_i;

  fdc_line_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .send_i(send), .data_i(sdata),
    .word_o(rx_word_i), .line_o(rx_line_i));
  fdc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_line_i(rx_line_i),
    .tx_loop_line_i(tx_loop_line_i), .rx_word_i(rx_word_i), .tx_word_i(tx_word_i),
    .cfg_o(cfg_o), .rx_line_o(rx_line_o), .own_word_o(own_word_o),
    .shared_word_o(shared_word_o), .tx_word_o(tx_word_o), .frame_lock_o(frame_lock_o));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Word compare: data only matters when a valid word is expected
  task automatic chkw(input string what, input fdc_word_t e, input fdc_word_t g);
    chk(what, {19'h0, e}, {19'h0, g.valid, e.valid ? g.data : e.data});
  endtask

  // One APB transfer; request held until pready is seen, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready_o});
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk("write_err", {31'h0, e}, {31'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk("read_data", exp, r);
    chk("read_err", {31'h0, e}, {31'h0, er});
  endtask

  // Reset values, then each single-bit control flag alone, then the write mask
  task automatic t_regs();
    rd(FDC_OFF_CTRL, 32'h0, 1'b0);
    for (int k = 0; k < 4; k++)
      rd(FDC_OFF_SYNC1 + 8'(4 * k), 32'(k + 1), 1'b0);
    for (int b = 8; b < 17; b++)
    begin
      wr(FDC_OFF_CTRL, 32'h1 << b, 1'b0);
      chk("cfg", 32'h1 << b, 32'(cfg_o));
    end
    wr(FDC_OFF_CTRL, 32'h00001000, 1'b0);
    chk("slew", 32'h1, {31'h0, cfg_o.tx_slew_select});
    wr(FDC_OFF_CTRL, 32'hFFFFFFFF, 1'b0);
    rd(FDC_OFF_CTRL, 32'h0001FF77, 1'b0);
  endtask

  // Every rate code, receive and transmit set apart
  task automatic t_rate();
    for (int c = 0; c < 8; c++)
    begin
      wr(FDC_OFF_CTRL, 32'((7 - c) << 4 | c), 1'b0);
      rd(FDC_OFF_RATE, (32'h180 << (7 - c)) << 16 | (32'h180 << c), 1'b0);
      rd(FDC_OFF_FRAME, (32'h20 << (7 - c)) << 16 | (32'h20 << c), 1'b0);
    end
  endtask

  // Zero patterns and unmapped places are refused, pattern kept
  task automatic t_refuse();
    wr(FDC_OFF_SYNC2, 32'h0, 1'b1);
    wr(FDC_OFF_SYNC2, 32'hF000, 1'b1);
    rd(FDC_OFF_SYNC2, 32'h2, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++)
      wr(FDC_OFF_SYNC1 + 8'(4 * k), 32'hA50 + 32'(k), 1'b0);
  endtask

  // One receive word and one transmit word through the chosen routing
  task automatic t_route(input logic [31:0] ctrl, input fdc_word_t e_own, input fdc_word_t e_sh,
    input fdc_word_t e_tx, input fdc_word_t e_idle, input logic e_line);
    wr(FDC_OFF_CTRL, ctrl, 1'b0);
    send <= 1'b1;
    sdata <= 12'h8A5;
    tx_word_i <= {1'b1, 12'h3C6};
    @(posedge clk_i);
    send <= 1'b0;
    tx_word_i.valid <= 1'b0;
    // Transmit word stands one cycle after its input, receive words one cycle later still
    @(posedge clk_i);
    chkw("tx", e_tx, tx_word_o);
    @(posedge clk_i);
    chkw("own", e_own, own_word_o);
    chkw("shared", e_sh, shared_word_o);
    chk("line", {31'h0, e_line}, {31'h0, rx_line_o});
    @(posedge clk_i);
    chkw("own_after", e_idle, own_word_o);
  endtask

  // Four patterns every gap words; lock expected only at the sub-frame spacing
  task automatic t_hunt(input logic ad, input int gap, input logic exp);
    wr(FDC_OFF_CTRL, 32'h8000 | {23'h0, ad, 8'h00}, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      for (int w = 0; w < gap; w++)
      begin
        send <= 1'b1;
        sdata <= (w == 0) ? 12'(12'hA50 + k) : 12'h555;
        @(posedge clk_i);
      end
      if (k == 2)
        chk("early_lock", 32'h0, {31'h0, frame_lock_o});
    end
    send <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("lock", {31'h0, exp}, {31'h0, frame_lock_o});
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_rate();
    t_refuse();
    t_route(32'h18000, {1'b1, 12'h8A5}, '0, {1'b1, 12'h3C6}, '0, 1'b1);
    t_route(32'h0C000, '0, {1'b1, 12'h8A5}, '0, '0, 1'b1);
    t_route(32'h00000, '0, '0, '0, '0, 1'b1);
    t_route(32'h1A000, {1'b1, 12'h3C6}, '0, {1'b1, 12'h3C6}, '0, 1'b0);
    t_hunt(1'b1, 32, 1'b1);
    rd(FDC_OFF_STATUS, 32'h7, 1'b0);
    t_hunt(1'b0, 32, 1'b0);
    rd(FDC_OFF_STATUS, 32'h100, 1'b0);
    wr(FDC_OFF_STATUS, 32'h0, 1'b0);
    rd(FDC_OFF_STATUS, 32'h0, 1'b0);
    t_hunt(1'b1, 31, 1'b0);
    results();
  end

  // Watchdog: the whole sequence needs about 650 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    results();
  end
endmodule
